// ---- hw/awr_map.svh ----
`ifndef AWR_MAP_SVH
`define AWR_MAP_SVH

// Byte offsets on the register bus, one aligned word each
`define AWR_OFS_RCSC   8'h00
`define AWR_OFS_RXBUF  8'h04
`define AWR_OFS_TXSC   8'h08
`define AWR_OFS_BAUD   8'h0C
`define AWR_OFS_DIVH   8'h10
`define AWR_OFS_DIVL   8'h14
`define AWR_OFS_INTC   8'h18

// Receive status/control field positions
`define AWR_RCSC_SERIAL_PORT_ENABLE  7
`define AWR_RCSC_RX9   6
`define AWR_RCSC_CONTINUOUS_RECEIVE_ENABLE  4
`define AWR_RCSC_ADDRESS_FILTER_ENABLE 3
`define AWR_RCSC_FRAMING_ERROR_FLAG  2
`define AWR_RCSC_OVERRUN_ERROR_FLAG  1
`define AWR_RCSC_RECEIVED_NINTH_BIT  0

// Transmit status/control fields the receiver depends on
`define AWR_TXSC_SYNC  4
`define AWR_TXSC_BRGH  2

// Baud control field positions
`define AWR_BAUD_RCIDL 6
`define AWR_BAUD_BRG16 3
`define AWR_BAUD_WUE   1

// Interrupt control field positions
`define AWR_INTC_IE    1
`define AWR_INTC_FLAG  0

// Reset values
`define AWR_RST_BYTE   8'h00
`define AWR_RST_WORD   32'h0000_0000

// Oversampling ratio of the data recovery shifter
`define AWR_OVERSAMPLE 16
// Extra prescale in the slow x64 mode
`define AWR_SLOW_PRESC 2'h3

`endif

// ---- hw/awr_pkg.sv ----
package awr_pkg;

  // Receiver sequencer states
  typedef enum logic [2:0] {
    AWR_IDLE,
    AWR_START,
    AWR_DATA,
    AWR_STOP,
    AWR_WAKE_ARM,
    AWR_WAKE_LOW
  } awr_state_type;

endpackage

// ---- hw/awr_receiver.sv ----
`timescale 1ns/1ps
`include "awr_map.svh"

module awr_receiver #(
  parameter int OVS = `AWR_OVERSAMPLE
) (
  input  logic        mclk,
  input  logic        sys_rst,
  input  logic        hsel,
  input  logic [31:0] haddr,
  input  logic [1:0]  htrans,
  input  logic        hwrite,
  input  logic [2:0]  hsize,
  input  logic [31:0] hwdata,
  input  logic        hready,
  output logic [31:0] hrdata,
  output logic        hreadyout,
  output logic        hresp,
  input  logic        serialReceiveLine,
  input  logic        sleepMode,
  output logic        rxIntReq
);
  import awr_pkg::*;

  localparam int SW = $clog2(OVS);
  localparam logic [SW-1:0] LAST = SW'(OVS - 1);
  localparam logic [SW-1:0] MID  = SW'(OVS / 2 - 1);

  // The counters below rely on a power of two that fits the mid-bit logic
  if (OVS < 4 || OVS > 64 || (OVS & (OVS - 1)) != 0) begin : g_chk
    $error("OVS must be a power of two from 4 to 64");
  end

  logic          serialPortEnable_q;
  logic          ninthBitReceiveEnable_q;
  logic          continuousReceiveEnable_q;
  logic          addressFilterEnable_q;
  logic          framingErrorFlag_q;
  logic          overrunErrorFlag_q;
  logic          receivedNinthBit_q;
  logic [7:0]    receiveBuffer_q;
  logic          receiveCompleteFlag_q;
  logic          receiveInterruptEnable_q;
  logic          wakeOnBreakEnable_q;
  logic          clockedMode_q;
  logic          highSpeed_q;
  logic          wideDivisor_q;
  logic [7:0]    divHigh_q;
  logic [7:0]    divLow_q;
  logic          wrPend_q;
  logic [7:0]    wrAddr_q;
  logic [31:0]   hrdata_q;
  logic          lineS1_q;
  logic          lineS2_q;
  logic          lineS3_q;
  logic          line_q;
  logic          lineP_q;
  logic [15:0]   brgCnt_q;
  logic [1:0]    presc_q;
  awr_state_type state_q;
  logic [SW-1:0] smpCnt_q;
  logic [3:0]    bitCnt_q;
  logic [8:0]    shift_q;

  logic          addrPhase;
  logic          rdBuffer;
  logic          fallEdge;
  logic          riseEdge;
  logic          baudTick;
  logic          sampTick;
  logic          rxActive;
  logic          wakeMode;
  logic          frameDone;
  logic          frameAccept;
  logic          frameLoad;
  logic          overrunHit;
  logic          wakeEvent;
  logic          wakeDone;
  logic          rxIdle;
  logic [15:0]   divisor;
  logic [3:0]    lastBit;
  logic [7:0]    frameData;
  logic [7:0]    rdByte;

  // Write strobe for one register, used by every write process
  function automatic logic wrHit(input logic [7:0] ofs);
    wrHit = wrPend_q && (wrAddr_q == ofs);
  endfunction

  // Zero-wait slave: every transfer completes in one data phase, OKAY
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = hrdata_q;
  assign addrPhase = hsel && hready && htrans[1];
  assign rdBuffer  = addrPhase && !hwrite && (haddr[7:0] == `AWR_OFS_RXBUF);

  // Capture the address phase; the write lands in the data phase
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      wrPend_q <= 1'b0;
      wrAddr_q <= `AWR_RST_BYTE;
    end else begin
      wrPend_q <= addrPhase && hwrite;
      wrAddr_q <= haddr[7:0];
    end
  end

  // Read multiplexer; unmapped words read as zero
  always_comb begin
    rdByte = `AWR_RST_BYTE;
    case (haddr[7:0])
      `AWR_OFS_RCSC: begin
        rdByte[`AWR_RCSC_SERIAL_PORT_ENABLE]  = serialPortEnable_q;
        rdByte[`AWR_RCSC_RX9]   = ninthBitReceiveEnable_q;
        rdByte[`AWR_RCSC_CONTINUOUS_RECEIVE_ENABLE]  = continuousReceiveEnable_q;
        rdByte[`AWR_RCSC_ADDRESS_FILTER_ENABLE] = addressFilterEnable_q;
        rdByte[`AWR_RCSC_FRAMING_ERROR_FLAG]  = framingErrorFlag_q;
        rdByte[`AWR_RCSC_OVERRUN_ERROR_FLAG]  = overrunErrorFlag_q;
        rdByte[`AWR_RCSC_RECEIVED_NINTH_BIT]  = receivedNinthBit_q;
      end
      `AWR_OFS_RXBUF: rdByte = receiveBuffer_q;
      `AWR_OFS_TXSC: begin
        rdByte[`AWR_TXSC_SYNC]  = clockedMode_q;
        rdByte[`AWR_TXSC_BRGH]  = highSpeed_q;
      end
      `AWR_OFS_BAUD: begin
        rdByte[`AWR_BAUD_RCIDL] = rxIdle;
        rdByte[`AWR_BAUD_BRG16] = wideDivisor_q;
        rdByte[`AWR_BAUD_WUE]   = wakeOnBreakEnable_q;
      end
      `AWR_OFS_DIVH: rdByte = divHigh_q;
      `AWR_OFS_DIVL: rdByte = divLow_q;
      `AWR_OFS_INTC: begin
        rdByte[`AWR_INTC_IE]    = receiveInterruptEnable_q;
        rdByte[`AWR_INTC_FLAG]  = receiveCompleteFlag_q;
      end
      default: rdByte = `AWR_RST_BYTE;
    endcase
  end

  // Read data is registered at the address phase, held in the data phase
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      hrdata_q <= `AWR_RST_WORD;
    end else if (addrPhase && !hwrite) begin
      hrdata_q <= {24'h00_0000, rdByte};
    end
  end

  // Receive status/control: software writable control bits
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      serialPortEnable_q        <= 1'b0;
      ninthBitReceiveEnable_q   <= 1'b0;
      continuousReceiveEnable_q <= 1'b0;
      addressFilterEnable_q     <= 1'b0;
    end else if (wrHit(`AWR_OFS_RCSC)) begin
      serialPortEnable_q        <= hwdata[`AWR_RCSC_SERIAL_PORT_ENABLE];
      ninthBitReceiveEnable_q   <= hwdata[`AWR_RCSC_RX9];
      continuousReceiveEnable_q <= hwdata[`AWR_RCSC_CONTINUOUS_RECEIVE_ENABLE];
      addressFilterEnable_q     <= hwdata[`AWR_RCSC_ADDRESS_FILTER_ENABLE];
    end
  end

  // Mode and rate selection shared with the absent transmitter
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      clockedMode_q <= 1'b0;
      highSpeed_q   <= 1'b0;
      wideDivisor_q <= 1'b0;
      divHigh_q     <= `AWR_RST_BYTE;
      divLow_q      <= `AWR_RST_BYTE;
    end else begin
      if (wrHit(`AWR_OFS_TXSC)) begin
        clockedMode_q <= hwdata[`AWR_TXSC_SYNC];
        highSpeed_q   <= hwdata[`AWR_TXSC_BRGH];
      end
      if (wrHit(`AWR_OFS_BAUD)) begin
        wideDivisor_q <= hwdata[`AWR_BAUD_BRG16];
      end
      if (wrHit(`AWR_OFS_DIVH)) begin
        divHigh_q <= hwdata[7:0];
      end
      if (wrHit(`AWR_OFS_DIVL)) begin
        divLow_q <= hwdata[7:0];
      end
    end
  end

  // Interrupt enable lives in its own control word
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      receiveInterruptEnable_q <= 1'b0;
    end else if (wrHit(`AWR_OFS_INTC)) begin
      receiveInterruptEnable_q <= hwdata[`AWR_INTC_IE];
    end
  end

  // hardware auto-clear
  // A software write in the same cycle wins, so a fresh arm is never lost
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      wakeOnBreakEnable_q <= 1'b0;
    end else if (wrHit(`AWR_OFS_BAUD)) begin
      wakeOnBreakEnable_q <= hwdata[`AWR_BAUD_WUE];
    end else if (wakeDone) begin
      wakeOnBreakEnable_q <= 1'b0;
    end
  end

  // Three-stage pin synchroniser; a level counts once stages two and three agree
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      lineS1_q <= 1'b1;
      lineS2_q <= 1'b1;
      lineS3_q <= 1'b1;
      line_q   <= 1'b1;
      lineP_q  <= 1'b1;
    end else begin
      lineS1_q <= serialReceiveLine;
      lineS2_q <= lineS1_q;
      lineS3_q <= lineS2_q;
      if (lineS2_q == lineS3_q) begin
        line_q <= lineS3_q;
      end
      lineP_q <= line_q;
    end
  end

  assign fallEdge = lineP_q && !line_q;
  assign riseEdge = !lineP_q && line_q;

  // Divisor width follows the 16-bit select; otherwise high byte ignored
  assign divisor = wideDivisor_q ? {divHigh_q, divLow_q} : {8'h00, divLow_q};

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      brgCnt_q <= 16'h0000;
      presc_q  <= 2'h0;
    end else if (!sleepMode) begin
      if (baudTick) begin
        brgCnt_q <= divisor;
        presc_q  <= presc_q + 2'h1;
      end else begin
        brgCnt_q <= brgCnt_q - 16'h0001;
      end
    end
  end

  // x16 sample enable
  // Slow mode divides by four more so the sample rate stays sixteen per bit
  assign baudTick = !sleepMode && (brgCnt_q == 16'h0000);
  assign sampTick = baudTick &&
                    (highSpeed_q || wideDivisor_q || presc_q == `AWR_SLOW_PRESC);

  // continuous enable gate
  // An overrun freezes reception until software clears the receive enable
  assign rxActive = serialPortEnable_q && !clockedMode_q &&
                    continuousReceiveEnable_q && !sleepMode && !overrunErrorFlag_q;
  assign wakeMode = wakeOnBreakEnable_q && serialPortEnable_q && !clockedMode_q;
  assign rxIdle   = (state_q == AWR_IDLE);

  assign lastBit = ninthBitReceiveEnable_q ? 4'h8 : 4'h7;

  // Receive sequencer: start check at mid-bit, then one sample per bit time
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      state_q  <= AWR_IDLE;
      smpCnt_q <= '0;
      bitCnt_q <= 4'h0;
      shift_q  <= 9'h000;
    end else if (wakeMode) begin
      case (state_q)
        AWR_WAKE_ARM: begin
          if (fallEdge) begin
            state_q <= AWR_WAKE_LOW;
          end
        end
        AWR_WAKE_LOW: begin
          // rising edge resumes
          // A re-arm written in the same cycle keeps the enable set, so arm again
          if (riseEdge) begin
            state_q <= (wrHit(`AWR_OFS_BAUD) && hwdata[`AWR_BAUD_WUE]) ? AWR_WAKE_ARM :
                                                                       AWR_IDLE;
          end
        end
        default: state_q <= AWR_WAKE_ARM;
      endcase
    end else if (!rxActive) begin
      state_q <= AWR_IDLE;
    end else begin
      case (state_q)
        AWR_IDLE: begin
          smpCnt_q <= '0;
          if (!line_q) begin
            state_q <= AWR_START;
          end
        end
        AWR_START: begin
          if (sampTick) begin
            smpCnt_q <= smpCnt_q + 1'b1;
            if (smpCnt_q == MID) begin
              // A glitch shorter than half a bit is not a start
              state_q  <= line_q ? AWR_IDLE : AWR_DATA;
              smpCnt_q <= '0;
              bitCnt_q <= 4'h0;
            end
          end
        end
        AWR_DATA: begin
          if (sampTick) begin
            smpCnt_q <= smpCnt_q + 1'b1;
            if (smpCnt_q == LAST) begin
              shift_q  <= {line_q, shift_q[8:1]};
              bitCnt_q <= bitCnt_q + 4'h1;
              if (bitCnt_q == lastBit) begin
                state_q <= AWR_STOP;
              end
            end
          end
        end
        AWR_STOP: begin
          if (sampTick) begin
            smpCnt_q <= smpCnt_q + 1'b1;
            if (smpCnt_q == LAST) begin
              state_q <= AWR_IDLE;
            end
          end
        end
        default: state_q <= AWR_IDLE;
      endcase
    end
  end

  // Frame ends at the stop-bit sample point
  assign frameDone = rxActive && !wakeMode && (state_q == AWR_STOP) &&
                     sampTick && (smpCnt_q == LAST);
  assign frameAccept = frameDone &&
                       !(addressFilterEnable_q && ninthBitReceiveEnable_q && !shift_q[8]);
  // An unread buffer makes the new frame an overrun, the old byte is kept
  assign frameLoad  = frameAccept && !receiveCompleteFlag_q;
  assign overrunHit = frameAccept && receiveCompleteFlag_q;
  // Eight-bit frames sit one place higher in the shifter
  assign frameData  = ninthBitReceiveEnable_q ? shift_q[7:0] : shift_q[8:1];
  assign wakeEvent  = wakeMode && (state_q == AWR_WAKE_ARM) && fallEdge;
  assign wakeDone   = wakeMode && (state_q == AWR_WAKE_LOW) && riseEdge;

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      receiveBuffer_q    <= `AWR_RST_BYTE;
      receivedNinthBit_q <= 1'b0;
    end else if (frameLoad) begin
      receiveBuffer_q    <= frameData;
      receivedNinthBit_q <= ninthBitReceiveEnable_q && shift_q[8];
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      framingErrorFlag_q <= 1'b0;
      overrunErrorFlag_q <= 1'b0;
    end else if (!continuousReceiveEnable_q) begin
      framingErrorFlag_q <= 1'b0;
      overrunErrorFlag_q <= 1'b0;
    end else begin
      if (frameLoad) begin
        framingErrorFlag_q <= !line_q;
      end
      if (overrunHit) begin
        overrunErrorFlag_q <= 1'b1;
      end
    end
  end

  // buffer read clears
  // A set in the same cycle as the read wins so no event is dropped
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      receiveCompleteFlag_q <= 1'b0;
    end else if (frameLoad || wakeEvent) begin
      receiveCompleteFlag_q <= 1'b1;
    end else if (rdBuffer) begin
      receiveCompleteFlag_q <= 1'b0;
    end
  end

  assign rxIntReq = receiveCompleteFlag_q && receiveInterruptEnable_q;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);

  AST_IRQ_NEEDS_ENABLE: assert property (
    rxIntReq |-> receiveInterruptEnable_q && receiveCompleteFlag_q
  ) else $error("interrupt raised without enable");

  AST_CONTINUOUS_RECEIVE_ENABLE_CLEARS_ERRORS: assert property (
    !continuousReceiveEnable_q |=> !framingErrorFlag_q && !overrunErrorFlag_q
  ) else $error("errors kept while receive disabled");

  AST_WAKE_SETS_FLAG: assert property (
    (state_q == AWR_WAKE_ARM && wakeMode && fallEdge) |=> receiveCompleteFlag_q
  ) else $error("wake event did not set flag");

  AST_WAKE_SUPPRESSES_RX: assert property (
    wakeMode && $past(wakeMode) |-> (state_q == AWR_WAKE_ARM || state_q == AWR_WAKE_LOW)
  ) else $error("receiver active during wake monitoring");

  AST_WAKE_AUTOCLEAR: assert property (
    (wakeMode && state_q == AWR_WAKE_LOW && riseEdge && !wrPend_q)
      |=> !wakeOnBreakEnable_q && state_q == AWR_IDLE
  ) else $error("wake enable not cleared on rising edge");

  AST_SLEEP_NO_FRAME: assert property (
    sleepMode |-> !frameDone && !sampTick
  ) else $error("frame completed during sleep");

  AST_FILTER_DISCARD: assert property (
    (frameDone && addressFilterEnable_q && ninthBitReceiveEnable_q && !shift_q[8])
      |=> $stable(receiveBuffer_q) && $stable(receivedNinthBit_q)
  ) else $error("filtered frame reached the buffer");

  AST_LOAD_DATA: assert property (
    frameLoad |=> receiveBuffer_q == $past(frameData) && receiveCompleteFlag_q
  ) else $error("buffer not loaded with frame data");

  AST_BIT_PERIOD: assert property (
    (state_q == AWR_DATA && rxActive && !wakeMode && sampTick && smpCnt_q == LAST)
      |=> smpCnt_q == '0
  ) else $error("sample counter did not wrap at bit end");

  AST_DISABLED_IDLE: assert property (
    !continuousReceiveEnable_q && !wakeMode |=> state_q == AWR_IDLE
  ) else $error("receiver left idle while disabled");

endmodule

// ---- test/awr_line_model.sv ----
`timescale 1ns/1ps

// Remote serial transmitter on the receive line; the line idles high
module awr_line_model #(
  parameter int BIT_CYC = 32
) (
  input  logic mclk,
  output logic serialReceiveLine
);
  // Bit length in clocks; the bench stretches it for the slow rate
  int bitCyc = BIT_CYC;

  // Idle level until the first character
  initial begin
    serialReceiveLine = 1'b1;
  end

  // Hold one level for n clocks, changed just after an edge
  task automatic hold(input logic v, input int n);
    serialReceiveLine <= v;
    repeat (n) @(posedge mclk);
  endtask

  task automatic send_frame(input logic [8:0] d, input int nb, input bit stopOk);
    hold(1'b0, bitCyc);
    for (int i = 0; i < nb; i++) begin
      hold(d[i], bitCyc);
    end
    // A bad stop stays low past mid-bit only, so no new start is seen
    if (!stopOk) begin
      hold(1'b0, bitCyc * 7 / 8);
    end
    hold(1'b1, bitCyc);
  endtask

  // long all-zero wake character, line left low
  task automatic zero_char(input int nz);
    hold(1'b0, (nz + 1) * bitCyc);
  endtask
endmodule

// ---- test/tb.sv ----
`timescale 1ns/1ps
`include "awr_map.svh"

module tb;
  localparam int BIT_CYC = 32;  // Divisor 1 at high speed: 2 mclk per tick
  logic        mclk;
  logic        sys_rst;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic        serialReceiveLine;
  logic        sleepMode;
  logic        rxIntReq;
  int          miscompares;
  int          n_tests;
  int          cycles;
  integer      seed;
  logic [31:0] rdv;
  logic [8:0]  dat;
  // Behavioural receiver state
  logic [7:0]  mCfg, mTx, mBuf;
  logic        mIe, mFlag, mNinth, mFerr, mOerr, mWue, mSleep;
  logic [7:0]  rwA [6] = '{`AWR_OFS_RCSC, `AWR_OFS_TXSC, `AWR_OFS_DIVH, `AWR_OFS_DIVL,
                           `AWR_OFS_INTC, 8'h1C};
  logic [7:0]  rwE [6] = '{8'hD8, 8'h14, 8'hFF, 8'hFF, 8'h02, 8'h00};
  logic [7:0]  badRc [4] = '{8'h10, 8'h90, 8'h80, 8'h90};
  logic [7:0]  badTx [4] = '{8'h04, 8'h14, 8'h04, 8'h04};

  awr_receiver i_dut (
    .mclk              (mclk),
    .sys_rst           (sys_rst),
    .hsel              (hsel),
    .haddr             (haddr),
    .htrans            (htrans),
    .hwrite            (hwrite),
    .hsize             (hsize),
    .hwdata            (hwdata),
    .hready            (hreadyout),
    .hrdata            (hrdata),
    .hreadyout         (hreadyout),
    .hresp             (hresp),
    .serialReceiveLine (serialReceiveLine),
    .sleepMode         (sleepMode),
    .rxIntReq          (rxIntReq)
  );

  awr_line_model #(.BIT_CYC(BIT_CYC)) i_line (
    .mclk              (mclk),
    .serialReceiveLine (serialReceiveLine)
  );

  // 100 MHz clock
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  // Hang guard, well above the expected run length
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      miscompares++;
      final_report();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value at %0t ns: seen 0x%h expected 0x%h", $time, seen, exp);
    end
  endtask

  // Single AHB-Lite word transfer; waits on hready in both phases
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] wd);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    haddr  <= {24'h000000, a};
    hwrite <= w;
    @(posedge mclk);
    while (hreadyout !== 1'b1) @(posedge mclk);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge mclk);
    while (hreadyout !== 1'b1) @(posedge mclk);
    rdv = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(a, 1'b1, d);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] m);
    bus(a, 1'b0, 32'h0);
    check(rdv & m, exp);
  endtask

  task automatic set_rcsc(input logic [7:0] v);
    wr(`AWR_OFS_RCSC, {24'h0, v});
    mCfg = v & 8'hD8;
    if (!v[4]) begin
      mFerr = 1'b0;
      mOerr = 1'b0;
    end
  endtask

  task automatic set_tx(input logic [7:0] v);
    wr(`AWR_OFS_TXSC, {24'h0, v});
    mTx = v;
  endtask

  // Send a frame, then apply it to the model; buffer is kept on overrun
  task automatic frame(input logic [8:0] d, input int nb, input bit stopOk);
    i_line.send_frame(d, nb, stopOk);
    repeat (12) @(posedge mclk);
    if (mCfg[7] && !mTx[4] && mCfg[4] && !mSleep && !mOerr && !mWue &&
        !(mCfg[3] && nb == 9 && !d[8])) begin
      if (mFlag) begin
        mOerr = 1'b1;
      end else begin
        mFlag  = 1'b1;
        mBuf   = d[7:0];
        mNinth = (nb == 9) ? d[8] : 1'b0;
        mFerr  = !stopOk;
      end
    end
  endtask

  // Flag, request, status and buffer against the model; buffer read clears flag
  task automatic check_all(input bit withBuf);
    rd_chk(`AWR_OFS_INTC, {30'h0, mIe, mFlag}, 32'hFFFFFFFF);
    check({31'h0, rxIntReq}, {31'h0, mIe & mFlag});
    rd_chk(`AWR_OFS_RCSC, {24'h0, mCfg | {5'h0, mFerr, mOerr, mNinth & mCfg[6]}},
           32'hFFFFFFFF);
    bus(`AWR_OFS_RXBUF, 1'b0, 32'h0);
    if (withBuf) check(rdv, {24'h0, mBuf});
    mFlag = 1'b0;
  endtask

  task automatic test_done(input string name);
    $display("test finished: %s", name);
  endtask

  task automatic final_report();
    $display("comparisons %0d, mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  initial begin
    seed = 32'hCE24860A;
    {miscompares, n_tests, cycles} = '0;
    {sys_rst, hsel, haddr, htrans, hwrite, hwdata, sleepMode} = '0;
    sys_rst = 1'b1;
    hsize = 3'h2;
    {mCfg, mTx, mBuf, mIe, mFlag, mNinth, mFerr, mOerr, mWue, mSleep} = '0;
    repeat (20) @(posedge mclk);
    sys_rst <= 1'b0;
    repeat (6) @(posedge mclk);
    // Reset values, including an unmapped word; idle bit of baud control masked
    for (int a = 0; a < 32; a += 4) begin
      rd_chk(a[7:0], 32'h0, (a == 12) ? 32'hFFFFFFBF : 32'hFFFFFFFF);
    end
    check({31'h0, hresp}, 32'h0);
    for (int i = 0; i < 6; i++) begin
      wr(rwA[i], 32'hFF);
      rd_chk(rwA[i], {24'h0, rwE[i]}, 32'hFFFFFFFF);
    end
    wr(`AWR_OFS_BAUD, 32'h0A);
    rd_chk(`AWR_OFS_BAUD, 32'h0A, 32'hFFFFFFBF);
    wr(`AWR_OFS_BAUD, 32'h00);
    wr(`AWR_OFS_DIVH, 32'h00);
    wr(`AWR_OFS_DIVL, 32'h01);
    // A write does not restart the generator: let the old count of up to 255 run out
    repeat (260) @(posedge mclk);
    wr(`AWR_OFS_INTC, 32'h00);
    set_tx(8'h04);
    set_rcsc(8'h90);
    test_done("registers");
    for (int i = 0; i < 4; i++) begin
      dat = 9'($random(seed));
      frame(dat, 8, 1'b1);
      check_all(1'b1);
    end
    test_done("eight-bit frames");
    mIe = 1'b1;
    wr(`AWR_OFS_INTC, 32'h02);
    set_rcsc(8'hD0);
    for (int i = 0; i < 4; i++) begin
      dat = 9'($random(seed));
      frame(dat, 9, 1'b1);
      check_all(1'b1);
    end
    test_done("nine-bit frames");
    // Data frame dropped, address frame kept
    set_rcsc(8'hD8);
    for (int i = 0; i < 2; i++) begin
      dat = 9'($random(seed));
      dat[8] = i[0];
      frame(dat, 9, 1'b1);
      check_all(1'b1);
    end
    test_done("address filter");
    set_rcsc(8'h90);
    frame(9'h0C3, 8, 1'b0);
    check_all(1'b1);
    set_rcsc(8'h80);
    set_rcsc(8'h90);
    check_all(1'b1);
    // Second and third frames arrive unread: overrun, then reception stops
    frame(9'h011, 8, 1'b1);
    frame(9'h022, 8, 1'b1);
    frame(9'h033, 8, 1'b1);
    check_all(1'b1);
    frame(9'h044, 8, 1'b1);
    check_all(1'b1);
    set_rcsc(8'h80);
    set_rcsc(8'h90);
    frame(9'h055, 8, 1'b1);
    check_all(1'b1);
    test_done("errors");
    // Port off, clocked mode, continuous off, asleep
    for (int i = 0; i < 4; i++) begin
      set_tx(badTx[i]);
      set_rcsc(badRc[i]);
      mSleep = (i == 3);
      sleepMode <= (i == 3);
      dat = 9'($random(seed));
      frame(dat, 8, 1'b1);
      check_all(1'b1);
    end
    set_tx(8'h04);
    set_rcsc(8'h90);
    test_done("refused frames");
    // Wake-up from a break while asleep
    wr(`AWR_OFS_BAUD, 32'h02);
    mWue = 1'b1;
    i_line.zero_char(8);
    mFlag = 1'b1;
    rd_chk(`AWR_OFS_INTC, {30'h0, mIe, mFlag}, 32'hFFFFFFFF);
    check({31'h0, rxIntReq}, 32'h1);
    rd_chk(`AWR_OFS_BAUD, 32'h02, 32'hFFFFFFBF);
    i_line.hold(1'b1, 40);
    mWue = 1'b0;
    rd_chk(`AWR_OFS_BAUD, 32'h00, 32'hFFFFFFBF);
    check_all(1'b0);
    rd_chk(`AWR_OFS_INTC, {30'h0, mIe, 1'b0}, 32'hFFFFFFFF);
    sleepMode <= 1'b0;
    mSleep = 1'b0;
    dat = 9'($random(seed));
    frame(dat, 8, 1'b1);
    check_all(1'b1);
    test_done("wake on break");
    // Sixteen-bit divisor with the high speed bit clear: one tick per reload
    set_tx(8'h00);
    wr(`AWR_OFS_BAUD, 32'h08);
    dat = 9'($random(seed));
    frame(dat, 8, 1'b1);
    check_all(1'b1);
    // Slow rate divides by four more; high divisor byte must be ignored here
    wr(`AWR_OFS_BAUD, 32'h00);
    wr(`AWR_OFS_DIVH, 32'hFF);
    wr(`AWR_OFS_DIVL, 32'h00);
    i_line.bitCyc = 64;
    dat = 9'($random(seed));
    frame(dat, 8, 1'b1);
    check_all(1'b1);
    test_done("rate selection");
    final_report();
  end
endmodule
